// ### rtl/vsc_classifier.sv
// What this block does
// - HD 750/720 lines, 1650/1280 words reports code 00h.
// - SD 525 lines, 1716/1440 words, 244 or 243 active per field: 16h.
// - SD 625 lines, 1728 words without better match reports 1Ah.
// - HD progressive 1125/1080 lines, 2048/2640 words reports 32h.
// - HD interlaced 1125/1080 lines, 2048/2200 words reports 3Dh.
// - Reset clears raster fields, code, locked and interlaced bits.
// - Bypass (enable pin low) clears the same fields.
// - Four-bit tolerance at 06Fh widens fractional detect, up to 4.
// - Fractional flag may be wrong for SD with payload packets.
// - Measure words and lines from references; update at end of line 12.
// - Locked only when timing synchronized and format supported.
// - Interlaced bit high for interlaced, low for progressive.
// - Fractional flag high when clock has 1000/1001 factor.
`timescale 1ns/100ps
`default_nettype none
module vsc_classifier
	import vsc_pkg::*;
(
	input wire logic i_clk,                   // 20 MHz clock
	input wire logic i_sys_rst,               // async reset, high
	input wire logic i_processing_enable_n,   // low selects bypass
	input wire logic i_word_en,               // one video word this cycle
	input wire logic i_sav,                   // SAV reference word
	input wire logic i_eav,                   // EAV reference word
	input wire logic i_vblank,                // V bit of reference
	input wire logic i_field,                 // F bit of reference
	input wire logic [10:0] i_line_num,       // line number of this line
	input wire logic i_sd_rate_flag,          // 1 = SD rate
	input wire logic i_timing_locked,         // generator synchronized
	input wire logic [7:0] i_rate_dev,        // offset from 1/1.001 rate
	input wire logic [11:0] i_host_addr,      // host register address
	input wire logic i_host_wr,               // host write strobe
	input wire logic [15:0] i_host_wdata,     // host write data
	input wire logic i_host_rd,               // host read strobe
	output logic [15:0] o_host_rdata,         // host read data
	output logic o_host_rvld,                 // read data valid pulse
	output logic [5:0] o_video_standard_code, // standard code
	output logic o_standard_locked,           // format locked
	output logic o_interlaced_flag,           // interlaced scan
	output logic o_frac_rate_flag,            // 1000/1001 rate
	output vsc_raster_s o_raster              // published raster
);

	logic bypass;
	assign bypass = ~i_processing_enable_n;

	// Per-line word counters
	logic [12:0] word_cnt_q;
	logic [12:0] act_cnt_q;
	logic in_active_q;
	logic [12:0] words_line_q;
	logic [12:0] words_act_q;

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			word_cnt_q <= 13'h0000;
			act_cnt_q <= 13'h0000;
			in_active_q <= 1'b0;
			words_line_q <= 13'h0000;
			words_act_q <= 13'h0000;
		end else if (bypass) begin
			word_cnt_q <= 13'h0000;
			act_cnt_q <= 13'h0000;
			in_active_q <= 1'b0;
			words_line_q <= 13'h0000;
			words_act_q <= 13'h0000;
		end else if (i_word_en) begin
			if (i_eav) begin
				words_line_q <= word_cnt_q;
				words_act_q <= act_cnt_q;
				word_cnt_q <= 13'h0001;
				act_cnt_q <= 13'h0000;
				in_active_q <= 1'b0;
			end else begin
				word_cnt_q <= word_cnt_q + 13'h0001;
				if (in_active_q) begin
					act_cnt_q <= act_cnt_q + 13'h0001;
				end
				if (i_sav) begin
					in_active_q <= 1'b1;
				end
			end
		end
	end

	// Per-frame line counters
	logic line_end;
	logic [10:0] cur_line_q;
	logic [10:0] act_lines_q;
	logic seen_f1_q;
	logic [10:0] lines_tot_q;
	logic [10:0] lines_act_q;
	logic intl_meas_q;
	logic frame_wrap;

	assign line_end = i_word_en & i_eav & ~bypass;
	assign frame_wrap = line_end && (i_line_num < cur_line_q);

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			cur_line_q <= 11'h000;
			act_lines_q <= 11'h000;
			seen_f1_q <= 1'b0;
			lines_tot_q <= 11'h000;
			lines_act_q <= 11'h000;
			intl_meas_q <= 1'b0;
		end else if (bypass) begin
			cur_line_q <= 11'h000;
			act_lines_q <= 11'h000;
			seen_f1_q <= 1'b0;
			lines_tot_q <= 11'h000;
			lines_act_q <= 11'h000;
			intl_meas_q <= 1'b0;
		end else if (line_end) begin
			cur_line_q <= i_line_num;
			if (frame_wrap) begin
				lines_tot_q <= cur_line_q;
				lines_act_q <= act_lines_q;
				intl_meas_q <= seen_f1_q;
				act_lines_q <= {10'h000, ~i_vblank};
				seen_f1_q <= i_field;
			end else begin
				act_lines_q <= act_lines_q + {10'h000, ~i_vblank};
				seen_f1_q <= seen_f1_q | i_field;
			end
		end
	end

	// Tolerance register; writes above the ceiling saturate
	logic [3:0] tol_q;

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			tol_q <= VSC_TOL_RESET;
		end else if (i_host_wr && i_host_addr == VSC_ADDR_TOLERANCE) begin
			if (i_host_wdata[3:0] > VSC_TOL_MAX) begin
				tol_q <= VSC_TOL_MAX;
			end else begin
				tol_q <= i_host_wdata[3:0];
			end
		end
	end

	// Fractional-rate decision; SD payload packets can upset it
	logic frac_now;
	assign frac_now = i_rate_dev <= (VSC_FRAC_BASE_DEV + {4'h0, tol_q});

	// Classification of the current measurement
	vsc_raster_s meas;
	logic [5:0] lk_code;
	logic lk_known;

	assign meas.words_line = words_line_q;
	assign meas.words_active = words_act_q;
	assign meas.lines_total = lines_tot_q;
	assign meas.lines_active = lines_act_q;

	vsc_std_lookup u_lookup (
		.i_raster(meas),
		.i_sd_rate_flag(i_sd_rate_flag),
		.i_interlaced(intl_meas_q),
		.o_code(lk_code),
		.o_known(lk_known)
	);

	// Update strobe at the end of the update line
	logic update;
	assign update = line_end && !frame_wrap && (cur_line_q == VSC_UPDATE_LINE);

	vsc_class_s cls_d;
	always_comb begin
		cls_d.code = lk_code;
		cls_d.locked = i_timing_locked & lk_known;
		cls_d.interlaced = intl_meas_q;
		cls_d.frac_rate = frac_now;
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_video_standard_code <= 6'h00;
			o_standard_locked <= 1'b0;
			o_interlaced_flag <= 1'b0;
			o_frac_rate_flag <= 1'b0;
			o_raster <= '0;
		end else if (bypass) begin
			o_video_standard_code <= 6'h00;
			o_standard_locked <= 1'b0;
			o_interlaced_flag <= 1'b0;
			o_frac_rate_flag <= 1'b0;
			o_raster <= '0;
		end else if (update) begin
			o_video_standard_code <= cls_d.code;
			o_standard_locked <= cls_d.locked;
			o_interlaced_flag <= cls_d.interlaced;
			o_frac_rate_flag <= cls_d.frac_rate;
			o_raster <= meas;
		end else if (!i_timing_locked) begin
			o_standard_locked <= 1'b0;
		end
	end

	// Host read port, one cycle latency
	logic [15:0] rdata;
	always_comb begin
		rdata = 16'h0000;
		if (i_host_addr == VSC_ADDR_WORDS_LINE) begin
			rdata = {3'h0, o_raster.words_line};
		end else if (i_host_addr == VSC_ADDR_WORDS_ACT) begin
			rdata = {3'h0, o_raster.words_active};
		end else if (i_host_addr == VSC_ADDR_LINES_TOT) begin
			rdata = {5'h00, o_raster.lines_total};
		end else if (i_host_addr == VSC_ADDR_LINES_ACT) begin
			rdata = {5'h00, o_raster.lines_active};
		end else if (i_host_addr == VSC_ADDR_STATUS) begin
			rdata[VSC_ST_CODE_LSB +: 6] = o_video_standard_code;
			rdata[VSC_ST_LOCK_BIT] = o_standard_locked;
			rdata[VSC_ST_INTL_BIT] = o_interlaced_flag;
			rdata[VSC_ST_FRAC_BIT] = o_frac_rate_flag;
		end else if (i_host_addr == VSC_ADDR_TOLERANCE) begin
			rdata = {12'h000, tol_q};
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_host_rdata <= 16'h0000;
			o_host_rvld <= 1'b0;
		end else begin
			o_host_rvld <= i_host_rd;
			if (i_host_rd) begin
				o_host_rdata <= rdata;
			end
		end
	end

endmodule : vsc_classifier
`default_nettype wire

// ### rtl/vsc_pkg.sv
package vsc_pkg;

	// Measured raster of one frame
	typedef struct packed {
		logic [12:0] words_line;
		logic [12:0] words_active;
		logic [10:0] lines_total;
		logic [10:0] lines_active;
	} vsc_raster_s;

	// Classification result and its status bits
	typedef struct packed {
		logic [5:0] code;
		logic locked;
		logic interlaced;
		logic frac_rate;
	} vsc_class_s;

	// Lookup entry; zero count or scan 2'h2 means do not care
	typedef struct packed {
		logic sd;
		logic [1:0] scan;
		logic [10:0] lines_total;
		logic [10:0] lines_active;
		logic [12:0] words_active;
		logic [12:0] words_line;
		logic [5:0] code;
	} vsc_entry_s;

	localparam int VSC_NUM_ENTRIES = 21;
	localparam logic [1:0] VSC_PROG = 2'h0;
	localparam logic [1:0] VSC_INTL = 2'h1;
	localparam logic [1:0] VSC_ANY = 2'h2;

	// Most specific entries first; the first hit wins
	localparam vsc_entry_s VSC_TABLE [VSC_NUM_ENTRIES] = '{
		'{1'h0, VSC_ANY, 11'h2EE, 11'h2D0, 13'h0500, 13'h0672, 6'h00},
		'{1'h0, VSC_ANY, 11'h2EE, 11'h2D0, 13'h05A0, 13'h0672, 6'h01},
		'{1'h0, VSC_ANY, 11'h2EE, 11'h2D0, 13'h06C0, 13'h07BC, 6'h05},
		'{1'h0, VSC_ANY, 11'h2EE, 11'h2D0, 13'h0500, 13'h0F78, 6'h06},
		'{1'h0, VSC_ANY, 11'h2EE, 11'h2D0, 13'h0D80, 13'h0F78, 6'h07},
		'{1'h0, VSC_ANY, 11'h2EE, 11'h2D0, 13'h0500, 13'h101D, 6'h08},
		'{1'h0, VSC_ANY, 11'h2EE, 11'h2D0, 13'h0E10, 13'h101D, 6'h09},
		'{1'h1, VSC_ANY, 11'h20D, 11'h1E7, 13'h05A0, 13'h06B4, 6'h16},
		'{1'h1, VSC_ANY, 11'h20D, 11'h1FB, 13'h05A0, 13'h06B4, 6'h17},
		'{1'h1, VSC_ANY, 11'h20D, 11'h1E7, 13'h0000, 13'h06B4, 6'h19},
		'{1'h1, VSC_ANY, 11'h20D, 11'h1FB, 13'h0000, 13'h06B4, 6'h1B},
		'{1'h1, VSC_ANY, 11'h271, 11'h000, 13'h05A0, 13'h06C0, 6'h18},
		'{1'h1, VSC_ANY, 11'h271, 11'h000, 13'h0000, 13'h06C0, 6'h1A},
		'{1'h0, VSC_PROG, 11'h465, 11'h438, 13'h0800, 13'h0898, 6'h31},
		'{1'h0, VSC_PROG, 11'h465, 11'h438, 13'h0800, 13'h0A50, 6'h32},
		'{1'h0, VSC_PROG, 11'h465, 11'h438, 13'h0800, 13'h0ABE, 6'h33},
		'{1'h0, VSC_INTL, 11'h465, 11'h438, 13'h0800, 13'h0898, 6'h3D},
		'{1'h0, VSC_INTL, 11'h465, 11'h438, 13'h0800, 13'h0A50, 6'h3E},
		'{1'h0, VSC_INTL, 11'h465, 11'h438, 13'h0800, 13'h0ABE, 6'h3F},
		'{1'h1, VSC_ANY, 11'h000, 11'h000, 13'h0000, 13'h0000, 6'h1E},
		'{1'h0, VSC_ANY, 11'h000, 11'h000, 13'h0800, 13'h0000, 6'h3A}
	};

	localparam logic [5:0] VSC_CODE_UNKNOWN_HD = 6'h1D;
	localparam logic [5:0] VSC_CODE_UNKNOWN_SD = 6'h1E;
	localparam logic [5:0] VSC_CODE_UNKNOWN_2K = 6'h3A;
	localparam logic [12:0] VSC_WORDS_2K = 13'h0800;

	localparam logic [10:0] VSC_UPDATE_LINE = 11'h00C;

	// Host register map (word addresses)
	localparam logic [11:0] VSC_ADDR_WORDS_LINE = 12'h020;
	localparam logic [11:0] VSC_ADDR_WORDS_ACT = 12'h021;
	localparam logic [11:0] VSC_ADDR_LINES_TOT = 12'h022;
	localparam logic [11:0] VSC_ADDR_LINES_ACT = 12'h023;
	localparam logic [11:0] VSC_ADDR_STATUS = 12'h024;
	localparam logic [11:0] VSC_ADDR_TOLERANCE = 12'h06F;

	// Status register fields
	localparam int VSC_ST_CODE_LSB = 0;
	localparam int VSC_ST_LOCK_BIT = 8;
	localparam int VSC_ST_INTL_BIT = 9;
	localparam int VSC_ST_FRAC_BIT = 10;

	localparam logic [3:0] VSC_TOL_RESET = 4'h0;
	localparam logic [3:0] VSC_TOL_MAX = 4'h4;
	localparam logic [7:0] VSC_FRAC_BASE_DEV = 8'h02;

endpackage : vsc_pkg

// ### rtl/vsc_std_lookup.sv
`timescale 1ns/100ps
`default_nettype none
module vsc_std_lookup
	import vsc_pkg::*;
(
	input wire vsc_raster_s i_raster, // measured raster
	input wire logic i_sd_rate_flag,  // 1 = SD rate
	input wire logic i_interlaced,    // measured scan type
	output logic [5:0] o_code,        // standard code
	output logic o_known              // a listed format matched
);

	logic [VSC_NUM_ENTRIES-1:0] hit;

	genvar gi;
	generate
		for (gi = 0; gi < VSC_NUM_ENTRIES; gi++) begin : g_entry
			localparam vsc_entry_s E = VSC_TABLE[gi];
			assign hit[gi] = (E.sd == i_sd_rate_flag)
				&& (E.scan == VSC_ANY || E.scan == {1'b0, i_interlaced})
				&& (E.lines_total == 11'h000
					|| E.lines_total == i_raster.lines_total)
				&& (E.lines_active == 11'h000
					|| E.lines_active == i_raster.lines_active)
				&& (E.words_active == 13'h0000
					|| E.words_active == i_raster.words_active)
				&& (E.words_line == 13'h0000
					|| E.words_line == i_raster.words_line);
		end
	endgenerate

	always_comb begin
		o_code = i_sd_rate_flag ? VSC_CODE_UNKNOWN_SD
			: VSC_CODE_UNKNOWN_HD;
		for (int i = VSC_NUM_ENTRIES - 1; i >= 0; i--) begin
			if (hit[i]) begin
				o_code = VSC_TABLE[i].code;
			end
		end
		o_known = (o_code != VSC_CODE_UNKNOWN_SD)
			&& (o_code != VSC_CODE_UNKNOWN_HD)
			&& (o_code != VSC_CODE_UNKNOWN_2K);
	end

endmodule : vsc_std_lookup
`default_nettype wire

// ### testbench/vsc_classifier_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module vsc_classifier_monitor
	import vsc_pkg::*;
(
	input wire logic i_clk, // clock
	input wire logic i_sys_rst, // reset
	input wire logic i_processing_enable_n, // bypass when low
	input wire logic i_word_en, // word strobe
	input wire logic i_eav, // line boundary
	input wire logic [10:0] i_line_num, // line number
	input wire logic i_timing_locked, // generator sync
	input wire logic i_host_rd, // read strobe
	input wire logic o_host_rvld, // read valid
	input wire logic [5:0] o_video_standard_code, // code
	input wire logic o_standard_locked, // locked
	input wire logic o_interlaced_flag, // interlaced
	input wire logic o_frac_rate_flag, // fractional
	input wire vsc_raster_s o_raster // raster
);
	logic [10:0] prev_line_q;
	logic upd;
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			prev_line_q <= 11'h000;
		end else if (!i_processing_enable_n) begin
			prev_line_q <= 11'h000;
		end else if (i_word_en && i_eav) begin
			prev_line_q <= i_line_num;
		end
	end
	// Once-per-frame publish point
	assign upd = i_word_en && i_eav && prev_line_q == VSC_UPDATE_LINE &&
		i_line_num > prev_line_q;
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	sequence s_cleared;
		o_video_standard_code == 6'h00 && !o_standard_locked &&
			!o_interlaced_flag && !o_frac_rate_flag && o_raster == '0;
	endsequence
	a_rd_gets_valid: assert property (
		i_host_rd |=> o_host_rvld) else $error("read gave no valid");
	a_valid_has_cause: assert property (
		o_host_rvld |-> $past(i_host_rd)) else $error("valid without read");
	a_reset_clears: assert property (
		$fell(i_sys_rst) |-> s_cleared) else $error("reset left state");
	a_bypass_clears: assert property (
		!i_processing_enable_n |=> s_cleared) else $error("bypass no clear");
	a_lock_needs_sync: assert property (
		!i_timing_locked |=> !o_standard_locked) else $error("lock unsynced");
	a_lock_known_std: assert property (
		o_standard_locked |-> !(o_video_standard_code inside
		{6'h1D, 6'h1E, 6'h3A})) else $error("lock on unknown code");
	a_publish_only: assert property (
		$changed({o_video_standard_code, o_interlaced_flag,
		o_frac_rate_flag, o_raster}) |-> $past(upd) ||
		!$past(i_processing_enable_n)) else $error("change off update");
	a_scan_2k: assert property (
		o_standard_locked && o_video_standard_code[5:4] == 2'h3 |->
		o_interlaced_flag == (o_video_standard_code >= 6'h3D))
		else $error("2K scan mismatch");
endmodule : vsc_classifier_monitor
bind vsc_classifier vsc_classifier_monitor u_vsc_classifier_monitor (.*);
`default_nettype wire

// ### testbench/vsc_video_src.sv
`timescale 1ns/100ps
`default_nettype none
module vsc_video_src (
	input wire logic i_clk, // video clock
	output logic o_word_en, // word strobe
	output logic o_sav, // SAV marker
	output logic o_eav, // EAV marker
	output logic o_vblank, // V bit
	output logic o_field, // F bit
	output logic [10:0] o_line_num // line number
);
	initial begin
		{o_word_en, o_sav, o_eav, o_vblank, o_field, o_line_num} = '0;
	end
	// One frame, then lines 1..12 and the EAV of line 13; only lines
	// 11 and 12 are full length to keep run time short
	task automatic run(input int wl, wa, lt, la, input logic intl);
		int ln;
		int n;
		int a;
		for (int k = 1; k <= lt + 13; k++) begin
			ln = (k > lt) ? k - lt : k;
			@(posedge i_clk);
			o_word_en <= 1'b1;
			o_eav <= 1'b1;
			o_sav <= 1'b0;
			o_line_num <= 11'(ln);
			o_vblank <= (ln <= lt - la);
			o_field <= intl && (ln > lt / 2);
			if (k == lt + 13) break;
			n = (ln == 11 || ln == 12) ? wl : 2;
			a = (n == wl) ? wa : 0;
			for (int w = 2; w <= n; w++) begin
				@(posedge i_clk);
				o_eav <= 1'b0;
				o_sav <= (w == n - a);
			end
		end
		@(posedge i_clk);
		// Released: line number, V and F no longer show the last value; SAV and EAV keep it
		o_word_en <= 1'b0;
		o_line_num <= ~o_line_num;
		o_vblank <= ~o_vblank;
		o_field <= ~o_field;
	endtask : run
endmodule : vsc_video_src
`default_nettype wire

// ### testbench/vsc_classifier_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(name, exp, got) \
	begin \
		checked++; \
		if ((got) !== (exp)) begin \
			miscompares++; \
			$display("Error %s: expected %h, seen %h", name, exp, got); \
		end \
	end
module vsc_classifier_tb
	import vsc_pkg::*;
;
	logic i_clk = 1'b0;
	logic i_sys_rst = 1'b1;
	logic i_processing_enable_n = 1'b1;
	logic i_sd_rate_flag = 1'b0;
	logic i_timing_locked = 1'b1;
	logic [7:0] i_rate_dev = 8'h06;
	logic [11:0] i_host_addr = 12'h000;
	logic i_host_wr = 1'b0;
	logic [15:0] i_host_wdata = 16'h0000;
	logic i_host_rd = 1'b0;
	logic i_word_en, i_sav, i_eav, i_vblank, i_field;
	logic [10:0] i_line_num;
	logic [15:0] o_host_rdata;
	logic o_host_rvld, o_standard_locked, o_interlaced_flag, o_frac_rate_flag;
	logic [5:0] o_video_standard_code;
	vsc_raster_s o_raster;
	int miscompares = 0;
	int checked = 0;
	vsc_classifier u_vsc_classifier (.*);
	vsc_video_src u_vsc_video_src (.i_clk(i_clk), .o_word_en(i_word_en),
		.o_sav(i_sav), .o_eav(i_eav), .o_vblank(i_vblank),
		.o_field(i_field), .o_line_num(i_line_num));
	always #25 i_clk = ~i_clk;
	function automatic logic [15:0] stw(input logic [5:0] c,
			input logic l, i, f);
		return {5'h00, f, i, l, 2'h0, c};
	endfunction : stw
	task automatic wreg(input logic [11:0] a, input logic [15:0] d);
		@(posedge i_clk);
		i_host_addr <= a;
		i_host_wdata <= d;
		i_host_wr <= 1'b1;
		@(posedge i_clk);
		i_host_wr <= 1'b0;
	endtask : wreg
	task automatic rc(input logic [11:0] a, input logic [15:0] e);
		@(posedge i_clk);
		i_host_addr <= a;
		i_host_rd <= 1'b1;
		@(posedge i_clk);
		i_host_rd <= 1'b0;
		#1;
		`CHK("read valid", 1'b1, o_host_rvld)
		`CHK("register", e, o_host_rdata)
	endtask : rc
	task automatic cls(input int wl, wa, lt, la, input logic intl, sd,
			input logic [15:0] st);
		@(posedge i_clk);
		i_sd_rate_flag <= sd;
		u_vsc_video_src.run(wl, wa, lt, la, intl);
		// Publish edge has just passed; let its update settle
		#1;
		`CHK("code", st[5:0], o_video_standard_code)
		rc(VSC_ADDR_STATUS, st);
		rc(VSC_ADDR_WORDS_LINE, 16'(wl));
		rc(VSC_ADDR_WORDS_ACT, 16'(wa));
		rc(VSC_ADDR_LINES_TOT, 16'(lt));
		rc(VSC_ADDR_LINES_ACT, 16'(la));
	endtask : cls
	task automatic summarize;
		if (miscompares == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : summarize
	initial begin
		repeat (12) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		rc(VSC_ADDR_STATUS, 16'h0000);
		rc(VSC_ADDR_WORDS_LINE, 16'h0000);
		rc(VSC_ADDR_TOLERANCE, 16'h0000);
		wreg(VSC_ADDR_TOLERANCE, 16'h0007);
		wreg(12'h030, 16'hFFFF);
		rc(VSC_ADDR_TOLERANCE, 16'h0004);
		rc(12'h030, 16'h0000);
		cls(16'h672, 16'h500, 16'h2EE, 16'h2D0, 0, 0, stw(6'h00, 1, 0, 1));
		@(posedge i_clk);
		i_rate_dev <= 8'h07;
		cls(16'h3E8, 16'h320, 16'h2EE, 16'h2D0, 0, 0, stw(6'h1D, 0, 0, 0));
		cls(16'h6B4, 16'h5A0, 16'h20D, 16'h1E7, 1, 1, stw(6'h16, 1, 1, 0));
		cls(16'h6C0, 16'h2D0, 16'h271, 16'h240, 1, 1, stw(6'h1A, 1, 1, 0));
		cls(16'h320, 16'h258, 16'h12C, 16'h0C8, 0, 1, stw(6'h1E, 0, 0, 0));
		cls(16'hA50, 16'h800, 16'h465, 16'h438, 0, 0, stw(6'h32, 1, 0, 0));
		cls(16'h834, 16'h800, 16'h465, 16'h438, 1, 0, stw(6'h3A, 0, 1, 0));
		cls(16'h898, 16'h800, 16'h465, 16'h438, 1, 0, stw(6'h3D, 1, 1, 0));
		@(posedge i_clk);
		i_timing_locked <= 1'b0;
		repeat (2) @(posedge i_clk);
		rc(VSC_ADDR_STATUS, stw(6'h3D, 0, 1, 0));
		@(posedge i_clk);
		i_processing_enable_n <= 1'b0;
		repeat (2) @(posedge i_clk);
		rc(VSC_ADDR_STATUS, 16'h0000);
		rc(VSC_ADDR_LINES_TOT, 16'h0000);
		rc(VSC_ADDR_TOLERANCE, 16'h0004);
		summarize();
	end
endmodule : vsc_classifier_tb
`default_nettype wire
